// *** logic/strap_pkg.sv ***
// Purpose: Constants and types shared by the strap decoder and the reference clock control.
// Assumes: One 250 MHz clock and a synchronous, active-high system reset.
// Notes: The decoder captures straps on the rising edge of the reset pin level.
//
// What this block does
// RQ1 - Interface straps: 00,01,10 pick I2C addresses 74h,75h,76h; 11 picks SPI slave.
// RQ2 - Three config straps form index 0 to 7 choosing the stored script.
// RQ3 - Strap address is only a default; a write replaces the target address.
// RQ4 - The power-up script may write the target address before host access.
// RQ5 - Reference mode 10 enables pin one as a single-ended clock input.
// RQ6 - Reference mode 01 enables the crystal driver across both pins.
// RQ7 - Per-pin load cap fields add picofarads above a fixed 6 pF minimum.
// RQ8 - Reference doubler bit doubles crystal or pin-one clock from 20 to 78.125 MHz.
// RQ9 - PLL input doubler bit doubles whichever input feeds the PLL.
// RQ10 - Configuring party must not cascade both doublers on the pin-one clock.
// RQ11 - Configuring party should not route doubler output to outputs via bypass.
// RQ12 - All strap levels are captured into the capture register at reset rise.
// RQ13 - Test strap 1 with config straps 011 starts normally but skips the script.
// RQ14 - Decoded mode and index hold until the next reset rising edge.
package strap_pkg;

    // ****************************************************************
    // Strap and address encodings
    // ****************************************************************
    localparam logic [1:0] IF_I2C_A   = 2'h0;
    localparam logic [1:0] IF_I2C_B   = 2'h1;
    localparam logic [1:0] IF_I2C_C   = 2'h2;
    localparam logic [1:0] IF_SPI     = 2'h3;
    localparam logic [6:0] ADDR_BASE  = 7'h74;
    localparam logic [2:0] SKIP_INDEX = 3'h3;

    // ****************************************************************
    // Capture register layout and reset values
    // ****************************************************************
    localparam int         CAP_IF_LSB   = 0;
    localparam int         CAP_AC_LSB   = 2;
    localparam int         CAP_TEST_BIT = 5;
    localparam logic [5:0] CAP_RESET    = 6'h00;

    // ****************************************************************
    // Reference input modes and analog figures
    // ****************************************************************
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_CRYSTAL  = 2'h1;
    localparam logic [1:0] MODE_SINGLE   = 2'h2;
    localparam int         MIN_CAP_PF    = 6;
    localparam int         DBL_MIN_KHZ   = 20000;
    localparam int         DBL_MAX_KHZ   = 78125;

    typedef enum logic [1:0] {
        HOST_I2C = 2'b00,
        HOST_SPI = 2'b01
    } host_mode_e;

endpackage

// *** logic/strap_if.sv ***
// Purpose: Carries the captured strap bits from the capture stage to the decoder.
// Assumes: Single clock domain.
// Notes: The capture stage drives, the top reads.
`timescale 1ns/1ps
interface strap_if;
    logic [5:0] cap;
    logic       fresh;
    modport src (output cap, output fresh);
    modport dst (input cap, input fresh);
endinterface

// *** logic/strap_capture.sv ***
// Purpose: Samples the strap pins on the rising edge of the reset pin.
// Assumes: Pins are synchronous to the clock.
// Notes: Strap value is taken by a clocked process after release, never by reset.
`timescale 1ns/1ps
module strap_capture (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_reset_n_pin,
    input  wire logic       i_test_strap,
    input  wire logic [2:0] i_config_index_strap,
    input  wire logic [1:0] i_if_strap,
    strap_if.src            o_strap
);
    typedef struct packed {
        logic       rst_seen;
        logic [5:0] cap;
        logic       fresh;
    } cap_s;

    cap_s state;
    cap_s next_state;

    // ****************************************************************
    // Edge detect and capture
    // ****************************************************************
    // The value only changes on a reset rise, so later pin moves are ignored.
    always_comb begin
        next_state          = state;
        next_state.rst_seen = i_reset_n_pin;
        next_state.fresh    = 1'b0;
        if (i_reset_n_pin && !state.rst_seen) begin
            next_state.cap   = {i_test_strap, i_config_index_strap, i_if_strap}; // see RQ12
            next_state.fresh = 1'b1;
        end
    end

    // Holding the register until the next edge keeps the decode steady. see RQ14
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state <= '{rst_seen: 1'b1, cap: strap_pkg::CAP_RESET, fresh: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign o_strap.cap   = state.cap;
    assign o_strap.fresh = state.fresh;
endmodule

// *** logic/strap_decode_and_refclk_ctrl.sv ***
// Purpose: Decodes reset straps and applies reference input and doubler settings.
// Assumes: Controls arrive as plain ports; analog cells take the enables below.
// Notes: Analog behaviour of the crystal and doublers lies outside this logic.
`timescale 1ns/1ps
module strap_decode_and_refclk_ctrl #(
    parameter int CAP_W = 5
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_reset_n_pin,
    input  wire logic             i_test_strap,
    input  wire logic [2:0]       i_config_index_strap,
    input  wire logic [1:0]       i_if_strap,
    input  wire logic             i_addr_wr,
    input  wire logic [6:0]       i_addr_wdata,
    input  wire logic [1:0]       i_ref_input_mode,
    input  wire logic [CAP_W-1:0] i_pin_one_load_cap,
    input  wire logic [CAP_W-1:0] i_pin_two_load_cap,
    input  wire logic             i_ref_doubler_en,
    input  wire logic             i_pll_input_doubler_en,
    output logic [5:0]            o_strap_capture_reg,
    output logic                  o_host_spi,
    output logic [6:0]            o_target_addr_reg,
    output logic [2:0]            o_config_index,
    output logic                  o_run_script,
    output logic                  o_pin_one_clk_en,
    output logic                  o_crystal_drv_en,
    output logic [CAP_W:0]        o_pin_one_cap_pf,
    output logic [CAP_W:0]        o_pin_two_cap_pf,
    output logic                  o_ref_doubler_on,
    output logic                  o_pll_doubler_on
);
    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The 6 pF minimum plus the widest field must fit in CAP_W+1 bits.
    if (CAP_W < 3 || CAP_W > 8) begin : g_bad_cap_w
        $error("CAP_W must be 3 to 8");
    end

    typedef struct packed {
        logic [6:0]       addr;
        logic             spi;
        logic [2:0]       idx;
        logic             run;
        logic             one_en;
        logic             xtal_en;
        logic [CAP_W:0]   cap_one;
        logic [CAP_W:0]   cap_two;
        logic             rdbl;
        logic             pdbl;
    } ctl_s;

    ctl_s state;
    ctl_s next_state;
    strap_if straps ();

    strap_capture u_cap (
        .i_clk                (i_clk),
        .i_sys_rst            (i_sys_rst),
        .i_reset_n_pin        (i_reset_n_pin),
        .i_test_strap         (i_test_strap),
        .i_config_index_strap (i_config_index_strap),
        .i_if_strap           (i_if_strap),
        .o_strap              (straps.src)
    );

    // Default target address from the interface straps; SPI gives the base.
    function automatic logic [6:0] strap_addr(input logic [1:0] ifs);
        if (ifs == strap_pkg::IF_SPI) begin
            strap_addr = strap_pkg::ADDR_BASE;
        end else begin
            strap_addr = strap_pkg::ADDR_BASE + {5'h00, ifs}; // see RQ1
        end
    endfunction

    // Capacitance in pF: fixed minimum plus the field, zero adding nothing.
    function automatic logic [CAP_W:0] total_cap(input logic [CAP_W-1:0] f);
        total_cap = (CAP_W+1)'(strap_pkg::MIN_CAP_PF) + {1'b0, f}; // see RQ7
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // A fresh capture reloads defaults; a write in that same cycle still wins.
    always_comb begin
        logic [1:0] ifs;
        logic [2:0] acs;
        logic       tst;
        ifs        = straps.cap[strap_pkg::CAP_IF_LSB +: 2];
        acs        = straps.cap[strap_pkg::CAP_AC_LSB +: 3];
        tst        = straps.cap[strap_pkg::CAP_TEST_BIT];
        next_state = state;
        if (straps.fresh) begin
            next_state.addr = strap_addr(ifs);
            next_state.spi  = (ifs == strap_pkg::IF_SPI); // see RQ1
            next_state.idx  = acs; // see RQ2
            next_state.run  = !(tst && acs == strap_pkg::SKIP_INDEX); // see RQ13
        end
        // Script or host writes land here alike, so any value is reachable early.
        if (i_addr_wr) begin
            next_state.addr = i_addr_wdata; // see RQ3 see RQ4
        end
        next_state.one_en  = (i_ref_input_mode == strap_pkg::MODE_SINGLE); // see RQ5
        next_state.xtal_en = (i_ref_input_mode == strap_pkg::MODE_CRYSTAL); // see RQ6
        next_state.cap_one = total_cap(i_pin_one_load_cap);
        next_state.cap_two = total_cap(i_pin_two_load_cap); // see RQ7
        // Doubler only has a source when the crystal driver or pin one is enabled.
        next_state.rdbl    = i_ref_doubler_en
                             && (i_ref_input_mode == strap_pkg::MODE_CRYSTAL
                                 || i_ref_input_mode == strap_pkg::MODE_SINGLE); // see RQ8
        // Cascading both doublers is left to the configuring party to avoid. see RQ10
        next_state.pdbl    = i_pll_input_doubler_en; // see RQ9
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state         <= '0;
            state.addr    <= strap_pkg::ADDR_BASE;
            state.run     <= 1'b1;
            state.cap_one <= (CAP_W+1)'(strap_pkg::MIN_CAP_PF);
            state.cap_two <= (CAP_W+1)'(strap_pkg::MIN_CAP_PF);
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_strap_capture_reg = straps.cap;
    assign o_host_spi          = state.spi;
    assign o_target_addr_reg   = state.addr;
    assign o_config_index      = state.idx;
    assign o_run_script        = state.run;
    assign o_pin_one_clk_en    = state.one_en;
    assign o_crystal_drv_en    = state.xtal_en;
    assign o_pin_one_cap_pf    = state.cap_one;
    assign o_pin_two_cap_pf    = state.cap_two;
    assign o_ref_doubler_on    = state.rdbl;
    assign o_pll_doubler_on    = state.pdbl;
endmodule

// *** tb/strap_board.sv ***
// Purpose: Board model: strap resistors, reset button and pins reused as GPIO.
// Assumes: Driven and sampled at the falling clock edge.
// Notes: After the reset pin rises the straps serve as GPIO and toggle.
`timescale 1ns/1ps
module strap_board (
    input  wire logic       i_clk,
    input  wire logic       i_press,
    input  wire logic [5:0] i_pull,
    output logic            o_reset_n_pin,
    output logic [5:0]      o_pins
);
    logic [5:0] gpio;
    initial begin
        o_reset_n_pin = 1'b1;
        o_pins = 6'h00;
        gpio = 6'h2a;
    end
    // Pins show the resistors while reset is low and at the rise; then GPIO
    // traffic flips them each cycle so a late sample would be seen.
    always @(negedge i_clk) begin
        gpio <= ~gpio;
        o_reset_n_pin <= !i_press;
        o_pins <= (i_press || !o_reset_n_pin) ? i_pull : gpio;
    end
endmodule

// *** tb/strap_ctrl_asserts.sv ***
// Purpose: Port checks for the strap decoder and reference control.
// Assumes: One clock, synchronous active-high reset.
// Notes: Ports grouped by width to keep the file short.
`timescale 1ns/1ps
module strap_ctrl_checker #(
    parameter int CAP_W = 5
) (
    input wire logic i_clk, i_sys_rst, i_reset_n_pin, i_test_strap, i_addr_wr,
    input wire logic i_ref_doubler_en, i_pll_input_doubler_en, o_host_spi, o_run_script,
    input wire logic o_pin_one_clk_en, o_crystal_drv_en, o_ref_doubler_on, o_pll_doubler_on,
    input wire logic [2:0]       i_config_index_strap, o_config_index,
    input wire logic [1:0]       i_if_strap, i_ref_input_mode,
    input wire logic [6:0]       i_addr_wdata, o_target_addr_reg,
    input wire logic [5:0]       o_strap_capture_reg,
    input wire logic [CAP_W-1:0] i_pin_one_load_cap, i_pin_two_load_cap,
    input wire logic [CAP_W:0]   o_pin_one_cap_pf, o_pin_two_cap_pf
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire [5:0] cap = o_strap_capture_reg;
    // The edge detector is held high in reset, so a rise counts only out of reset.
    sequence rise_s;
        $rose(i_reset_n_pin) && !$past(i_sys_rst);
    endsequence
    chk_strap_capture: assert property (rise_s |=>
        cap == $past({i_test_strap, i_config_index_strap, i_if_strap})) else $error("bad capture");
    chk_host_mode: assert property (rise_s |-> ##2 o_host_spi == (cap[1:0] == 2'h3))
        else $error("bad host mode");
    chk_addr_default: assert property (rise_s ##0 !i_addr_wr ##1 !i_addr_wr |=>
        o_target_addr_reg == 7'h74 + ((cap[1:0] == 2'h3) ? 7'h0 : 7'(cap[1:0])))
        else $error("bad default address");
    chk_config_index: assert property (rise_s |-> ##2 o_config_index == cap[4:2])
        else $error("bad index");
    chk_script_skip: assert property (rise_s |-> ##2
        o_run_script == !(cap[5] && cap[4:2] == 3'h3)) else $error("bad script run");
    chk_addr_write: assert property (i_addr_wr |=> o_target_addr_reg == $past(i_addr_wdata))
        else $error("address write lost");
    chk_decode_hold: assert property ($changed(o_config_index) || $changed(o_host_spi) |->
        $past(i_reset_n_pin, 2) && !$past(i_reset_n_pin, 3)) else $error("decode moved");
    chk_ref_mode: assert property (1 |=> o_crystal_drv_en == ($past(i_ref_input_mode) == 2'h1)
        && o_pin_one_clk_en == ($past(i_ref_input_mode) == 2'h2)) else $error("bad mode");
    chk_load_cap: assert property (1 |=> o_pin_one_cap_pf == $past(i_pin_one_load_cap) + 6
        && o_pin_two_cap_pf == $past(i_pin_two_load_cap) + 6) else $error("bad load cap");
    chk_doublers: assert property (1 |=> o_pll_doubler_on == $past(i_pll_input_doubler_en)
        && o_ref_doubler_on == ($past(i_ref_doubler_en) && $past(i_ref_input_mode) inside {2'h1, 2'h2}))
        else $error("bad doubler");
    cover property (rise_s ##2 o_host_spi);
    cover property (rise_s ##2 !o_run_script);
    cover property (i_addr_wr ##1 i_addr_wr);
    cover property (rise_s ##1 i_addr_wr);
endmodule
bind strap_decode_and_refclk_ctrl strap_ctrl_checker #(.CAP_W(CAP_W)) u_chk (.*);

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for strap decode and reference control.
// Assumes: Inputs change at the falling edge.
// Notes: Doublers are never cascaded on the pin-one clock.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {logic [1:0] m; logic [4:0] c1, c2; logic d, p, e1, ex, ed;} row_s;
    // Mode 10 never has both doublers on; that cascade is unsupported.
    // Doubler enables only ever feed the PLL path; no bypass route is driven.
    row_s rows [4] = '{'{2'h0, 5'h00, 5'h1f, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
        '{2'h1, 5'h1f, 5'h00, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
        '{2'h2, 5'h0c, 5'h05, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1},
        '{2'h3, 5'h01, 5'h1e, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0}};
    logic [5:0] straps [10] = '{6'h00, 6'h05, 6'h0a, 6'h0f, 6'h10, 6'h15, 6'h1a, 6'h1f, 6'h2c, 6'h24};
    logic i_clk = 1'b0, i_sys_rst = 1'b1, press = 1'b0, i_addr_wr = 1'b0, i_reset_n_pin;
    logic i_ref_doubler_en = 1'b0, i_pll_input_doubler_en = 1'b0, o_host_spi, o_run_script;
    logic o_pin_one_clk_en, o_crystal_drv_en, o_ref_doubler_on, o_pll_doubler_on;
    logic [5:0] pull = 6'h00, pins, o_strap_capture_reg, o_pin_one_cap_pf, o_pin_two_cap_pf, s;
    logic [6:0] i_addr_wdata = 7'h00, o_target_addr_reg;
    logic [4:0] i_pin_one_load_cap = 5'h00, i_pin_two_load_cap = 5'h00;
    logic [1:0] i_ref_input_mode = 2'h0;
    logic [2:0] o_config_index;
    wire logic       i_test_strap = pins[5];
    wire logic [2:0] i_config_index_strap = pins[4:2];
    wire logic [1:0] i_if_strap = pins[1:0];
    int n_mismatch = 0, comparisons = 0, cycles = 0, i;
    always #2 i_clk = ~i_clk;
    strap_board u_strap_board (.i_clk(i_clk), .i_press(press), .i_pull(pull),
        .o_reset_n_pin(i_reset_n_pin), .o_pins(pins));
    strap_decode_and_refclk_ctrl u_strap_decode_and_refclk_ctrl (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Hold the button three cycles, then wait well past the two-cycle decode.
    task automatic apply_straps(input logic [5:0] p);
        pull <= p;
        press <= 1'b1;
        repeat (3) @(negedge i_clk);
        press <= 1'b0;
        repeat (6) @(negedge i_clk);
    endtask
    task report_and_stop;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // A hung run counts as a mismatch; the whole sequence needs about 120 cycles.
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(negedge i_clk);
        i_sys_rst <= 1'b0;
        @(negedge i_clk);
        chk(o_strap_capture_reg, 6'h00);
        chk({o_target_addr_reg, o_run_script}, {7'h74, 1'b1});
        $display("test reset values done");
        for (i = 0; i < 4; i++) begin
            {i_ref_input_mode, i_pin_one_load_cap, i_pin_two_load_cap} <= {rows[i].m, rows[i].c1, rows[i].c2};
            {i_ref_doubler_en, i_pll_input_doubler_en} <= {rows[i].d, rows[i].p};
            repeat (2) @(negedge i_clk);
            chk({o_pin_one_clk_en, o_crystal_drv_en}, {rows[i].e1, rows[i].ex});
            chk({o_ref_doubler_on, o_pll_doubler_on}, {rows[i].ed, rows[i].p});
            chk({o_pin_one_cap_pf, o_pin_two_cap_pf}, {6'(rows[i].c1) + 6'h06, 6'(rows[i].c2) + 6'h06});
        end
        $display("test reference settings done");
        for (i = 0; i < 10; i++) begin
            s = straps[i];
            apply_straps(s);
            chk(o_strap_capture_reg, s);
            chk(o_host_spi, s[1:0] == 2'h3);
            chk(o_target_addr_reg, 7'h74 + ((s[1:0] == 2'h3) ? 7'h0 : 7'(s[1:0])));
            chk(o_config_index, s[4:2]);
            chk(o_run_script, !(s[5] && s[4:2] == 3'h3));
        end
        $display("test strap decode done");
        i_addr_wr <= 1'b1;
        i_addr_wdata <= 7'h11;
        @(negedge i_clk);
        chk(o_target_addr_reg, 7'h11);
        i_addr_wdata <= 7'h2b;
        @(negedge i_clk);
        i_addr_wr <= 1'b0;
        @(negedge i_clk);
        chk(o_target_addr_reg, 7'h2b);
        $display("test address writes done");
        // A write on the very cycle the straps reload must still win.
        pull <= 6'h01;
        press <= 1'b1;
        repeat (3) @(negedge i_clk);
        press <= 1'b0;
        repeat (2) @(negedge i_clk);
        i_addr_wr <= 1'b1;
        i_addr_wdata <= 7'h5a;
        @(negedge i_clk);
        i_addr_wr <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_target_addr_reg, 7'h5a);
        chk(o_strap_capture_reg, 6'h01);
        $display("test write during reload done");
        i_sys_rst <= 1'b1;
        repeat (2) @(negedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (5) @(negedge i_clk);
        chk({o_strap_capture_reg, o_config_index}, 9'h000);
        chk(o_target_addr_reg, 7'h74);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
